// File: verilog/mpw_pkg.sv
// Constants, register map and helpers for the motor PWM unit
package mpw_pkg;

    // Clock and timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int CLK_NS          = 100;
    localparam int DT_NS           = 1500;
    localparam int DT_CYCLES       = (DT_NS + CLK_NS - 1) / CLK_NS;
    localparam int PWM_HZ          = 10_000;
    localparam int PWM_PERIOD_CYC  = CLK_HZ / PWM_HZ;
    localparam int HALF_PERIOD     = PWM_PERIOD_CYC / 2;

    // Reset values
    localparam logic [15:0] PSTART_RST   = 16'(-HALF_PERIOD);
    localparam logic [15:0] PEND_RST     = 16'(HALF_PERIOD - 1);
    localparam logic [15:0] INIT_RST     = 16'(-HALF_PERIOD);
    localparam logic [15:0] EDGE_ON_RST  = 16'(-HALF_PERIOD / 2);
    localparam logic [15:0] EDGE_OFF_RST = 16'(HALF_PERIOD / 2);
    localparam logic [15:0] DTCNT_RST    = 16'(DT_CYCLES);
    localparam logic [15:0] TRIG_CMP_RST = 16'(DT_CYCLES / 4);
    localparam logic [3:0]  RATIO_RST    = 4'h1;
    localparam logic        RUN_RST      = 1'b0;
    localparam logic        F0EN_RST     = 1'b1;
    localparam logic        F1EN_RST     = 1'b1;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_PSTART    = 8'h08;
    localparam logic [7:0] OFS_PEND      = 8'h0c;
    localparam logic [7:0] OFS_INIT      = 8'h10;
    localparam logic [7:0] OFS_EDGE_BASE = 8'h14;
    localparam logic [7:0] OFS_DT_FIRST  = 8'h2c;
    localparam logic [7:0] OFS_DT_SECOND = 8'h30;
    localparam logic [7:0] OFS_TRIG_CMP  = 8'h34;
    localparam logic [7:0] OFS_COUNT     = 8'h38;

    // Control and status fields
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_F0EN_BIT  = 1;
    localparam int CTRL_F1EN_BIT  = 2;
    localparam int CTRL_RATIO_LSB = 4;
    localparam int ST_LATCH_BIT   = 0;
    localparam int ST_FAULT_BIT   = 1;
    localparam int ST_ARMED_BIT   = 2;

    // Bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } mpw_bus_t;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] mpw_be_merge(
        input logic [15:0] old_v,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [15:0] r;
        r = old_v;
        if (be[0]) r[7:0] = wdata[7:0];
        if (be[1]) r[15:8] = wdata[15:8];
        return r;
    endfunction : mpw_be_merge

endpackage : mpw_pkg

// File: verilog/mpw_dead_time.sv
// Dead-time insertion for one complementary phase leg
`timescale 1ns/100ps
module mpw_dead_time
    import mpw_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        raw_pwm,
    input  wire logic        out_en,
    input  wire logic [15:0] dt_first,
    input  wire logic [15:0] dt_second,
    output logic             pwm_hi,
    output logic             pwm_lo
);
    logic        raw_ff, nxt_raw;
    logic [15:0] cnt_ff, nxt_cnt;
    logic        hi_ff, nxt_hi;
    logic        lo_ff, nxt_lo;

    // Each edge of raw reloads the delay; the turning-on side waits
    always_comb begin
        nxt_raw = raw_pwm;
        nxt_cnt = cnt_ff;
        if (raw_pwm != raw_ff) begin
            nxt_cnt = raw_pwm ? dt_first : dt_second;
        end else if (cnt_ff != 16'h0000) begin
            nxt_cnt = cnt_ff - 16'h0001;
        end
        // Turn-off is immediate, turn-on only after the delay
        nxt_hi = out_en & raw_pwm & (nxt_cnt == 16'h0000);
        nxt_lo = out_en & ~raw_pwm & (nxt_cnt == 16'h0000);
    end

    // Registered outputs avoid glitches on the gate drive
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            raw_ff <= 1'b0;
            cnt_ff <= 16'h0000;
            hi_ff  <= 1'b0;
            lo_ff  <= 1'b0;
        end else begin
            raw_ff <= nxt_raw;
            cnt_ff <= nxt_cnt;
            hi_ff  <= nxt_hi;
            lo_ff  <= nxt_lo;
        end
    end

    assign pwm_hi = hi_ff;
    assign pwm_lo = lo_ff;

endmodule : mpw_dead_time

// File: verilog/mpw_motor_pwm_unit.sv
// Three-phase PWM with dead time, fault shutdown and converter trigger
`timescale 1ns/100ps
module mpw_motor_pwm_unit
    import mpw_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        fault0,
    input  wire logic        fault1_n,
    output logic [2:0]       pwm_hi,
    output logic [2:0]       pwm_lo,
    output logic             converter_trigger
);
    // Bus and register state
    mpw_bus_t    bus_ff, nxt_bus;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        run_ff, nxt_run;
    logic        f0en_ff, nxt_f0en;
    logic        f1en_ff, nxt_f1en;
    logic [3:0]  ratio_ff, nxt_ratio;
    logic [15:0] pstart_sh_ff, nxt_pstart_sh;
    logic [15:0] pend_sh_ff, nxt_pend_sh;
    logic [15:0] init_sh_ff, nxt_init_sh;
    logic [15:0] on_sh_ff [3];
    logic [15:0] nxt_on_sh [3];
    logic [15:0] off_sh_ff [3];
    logic [15:0] nxt_off_sh [3];
    logic [15:0] dt_first_ff, nxt_dt_first;
    logic [15:0] dt_second_ff, nxt_dt_second;
    logic [15:0] trig_cmp_ff, nxt_trig_cmp;
    logic        wr_go;

    // Active copies and counters
    logic [15:0] pstart_ff, nxt_pstart;
    logic [15:0] pend_ff, nxt_pend;
    logic [15:0] init_ff, nxt_init;
    logic [15:0] on_ff [3];
    logic [15:0] nxt_on [3];
    logic [15:0] off_ff [3];
    logic [15:0] nxt_off [3];
    logic [15:0] mcnt_ff, nxt_mcnt;
    logic [15:0] pcnt_ff [3];
    logic [15:0] nxt_pcnt [3];
    logic        armed_ff, nxt_armed;
    logic        latch_ff, nxt_latch;
    logic        master_reload;
    logic        fault_act;
    logic        out_en;
    logic [2:0]  raw_pwm;

    // Trigger submodule state
    logic        tick_ff, nxt_tick;
    logic [3:0]  skip_ff, nxt_skip;
    logic [15:0] tcnt_ff, nxt_tcnt;
    logic        tarm_ff, nxt_tarm;
    logic        trig_ff, nxt_trig;

    // One wait cycle on every access, then answer
    assign avs_waitrequest = (avs_read | avs_write) & (bus_ff == BUS_IDLE);
    assign avs_readdata    = rdata_ff;
    assign wr_go           = avs_write & (bus_ff == BUS_ACK);

    // Bus handshake and read mux
    always_comb begin
        nxt_bus   = bus_ff;
        nxt_rdata = rdata_ff;
        case (bus_ff)
            BUS_IDLE: begin
                if (avs_read | avs_write) nxt_bus = BUS_ACK;
                if (avs_read) begin
                    nxt_rdata = 32'h0000_0000;
                    case (avs_address)
                        OFS_CTRL: begin
                            nxt_rdata[CTRL_RUN_BIT]  = run_ff;
                            nxt_rdata[CTRL_F0EN_BIT] = f0en_ff;
                            nxt_rdata[CTRL_F1EN_BIT] = f1en_ff;
                            nxt_rdata[CTRL_RATIO_LSB +: 4] = ratio_ff;
                        end
                        OFS_STATUS: begin
                            nxt_rdata[ST_LATCH_BIT] = latch_ff;
                            nxt_rdata[ST_FAULT_BIT] = fault_act;
                            nxt_rdata[ST_ARMED_BIT] = armed_ff;
                        end
                        OFS_PSTART:    nxt_rdata[15:0] = pstart_sh_ff;
                        OFS_PEND:      nxt_rdata[15:0] = pend_sh_ff;
                        OFS_INIT:      nxt_rdata[15:0] = init_sh_ff;
                        OFS_DT_FIRST:  nxt_rdata[15:0] = dt_first_ff;
                        OFS_DT_SECOND: nxt_rdata[15:0] = dt_second_ff;
                        OFS_TRIG_CMP:  nxt_rdata[15:0] = trig_cmp_ff;
                        OFS_COUNT:     nxt_rdata[15:0] = mcnt_ff;
                        default: begin
                            for (int i = 0; i < 3; i++) begin
                                if (avs_address == 8'(OFS_EDGE_BASE + 8*i))
                                    nxt_rdata[15:0] = on_sh_ff[i];
                                if (avs_address == 8'(OFS_EDGE_BASE + 8*i + 4))
                                    nxt_rdata[15:0] = off_sh_ff[i];
                            end
                        end
                    endcase
                end
            end
            BUS_ACK: nxt_bus = BUS_IDLE;
            default: nxt_bus = BUS_IDLE;
        endcase
    end

    // Software-written registers; unmapped writes are dropped
    always_comb begin
        nxt_run       = run_ff;
        nxt_f0en      = f0en_ff;
        nxt_f1en      = f1en_ff;
        nxt_ratio     = ratio_ff;
        nxt_pstart_sh = pstart_sh_ff;
        nxt_pend_sh   = pend_sh_ff;
        nxt_init_sh   = init_sh_ff;
        nxt_dt_first  = dt_first_ff;
        nxt_dt_second = dt_second_ff;
        nxt_trig_cmp  = trig_cmp_ff;
        nxt_on_sh     = on_sh_ff;
        nxt_off_sh    = off_sh_ff;
        if (wr_go) begin
            if (avs_address == OFS_CTRL && avs_byteenable[0]) begin
                nxt_run   = avs_writedata[CTRL_RUN_BIT];
                nxt_f0en  = avs_writedata[CTRL_F0EN_BIT];
                nxt_f1en  = avs_writedata[CTRL_F1EN_BIT];
                nxt_ratio = avs_writedata[CTRL_RATIO_LSB +: 4];
            end
            if (avs_address == OFS_PSTART)
                nxt_pstart_sh = mpw_be_merge(pstart_sh_ff, avs_writedata,
                                             avs_byteenable);
            if (avs_address == OFS_PEND)
                nxt_pend_sh = mpw_be_merge(pend_sh_ff, avs_writedata,
                                           avs_byteenable);
            if (avs_address == OFS_INIT)
                nxt_init_sh = mpw_be_merge(init_sh_ff, avs_writedata,
                                           avs_byteenable);
            if (avs_address == OFS_DT_FIRST)
                nxt_dt_first = mpw_be_merge(dt_first_ff, avs_writedata,
                                            avs_byteenable);
            if (avs_address == OFS_DT_SECOND)
                nxt_dt_second = mpw_be_merge(dt_second_ff, avs_writedata,
                                             avs_byteenable);
            if (avs_address == OFS_TRIG_CMP)
                nxt_trig_cmp = mpw_be_merge(trig_cmp_ff, avs_writedata,
                                            avs_byteenable);
            for (int i = 0; i < 3; i++) begin
                if (avs_address == 8'(OFS_EDGE_BASE + 8*i))
                    nxt_on_sh[i] = mpw_be_merge(on_sh_ff[i], avs_writedata,
                                                avs_byteenable);
                if (avs_address == 8'(OFS_EDGE_BASE + 8*i + 4))
                    nxt_off_sh[i] = mpw_be_merge(off_sh_ff[i], avs_writedata,
                                                 avs_byteenable);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bus_ff       <= BUS_IDLE;
            rdata_ff     <= 32'h0000_0000;
            run_ff       <= RUN_RST;
            f0en_ff      <= F0EN_RST;
            f1en_ff      <= F1EN_RST;
            ratio_ff     <= RATIO_RST;
            pstart_sh_ff <= PSTART_RST;
            pend_sh_ff   <= PEND_RST;
            init_sh_ff   <= INIT_RST;
            dt_first_ff  <= DTCNT_RST;
            dt_second_ff <= DTCNT_RST;
            trig_cmp_ff  <= TRIG_CMP_RST;
            for (int i = 0; i < 3; i++) begin
                on_sh_ff[i]  <= EDGE_ON_RST;
                off_sh_ff[i] <= EDGE_OFF_RST;
            end
        end else begin
            bus_ff       <= nxt_bus;
            rdata_ff     <= nxt_rdata;
            run_ff       <= nxt_run;
            f0en_ff      <= nxt_f0en;
            f1en_ff      <= nxt_f1en;
            ratio_ff     <= nxt_ratio;
            pstart_sh_ff <= nxt_pstart_sh;
            pend_sh_ff   <= nxt_pend_sh;
            init_sh_ff   <= nxt_init_sh;
            dt_first_ff  <= nxt_dt_first;
            dt_second_ff <= nxt_dt_second;
            trig_cmp_ff  <= nxt_trig_cmp;
            on_sh_ff     <= nxt_on_sh;
            off_sh_ff    <= nxt_off_sh;
        end
    end

    // Full-cycle reload at period end; faults gate the outputs
    assign master_reload = run_ff & (mcnt_ff == pend_ff);
    assign fault_act = (f0en_ff & fault0) | (f1en_ff & ~fault1_n);
    assign out_en = run_ff & armed_ff & ~latch_ff & ~fault_act;

    // Counters, shadow transfer and fault latch
    always_comb begin
        nxt_pstart = pstart_ff;
        nxt_pend   = pend_ff;
        nxt_init   = init_ff;
        nxt_on     = on_ff;
        nxt_off    = off_ff;
        nxt_armed  = armed_ff;
        nxt_mcnt   = mcnt_ff;
        nxt_pcnt   = pcnt_ff;
        if (master_reload) begin
            // Duty only changes here, never mid-period
            nxt_pstart = pstart_sh_ff;
            nxt_pend   = pend_sh_ff;
            nxt_init   = init_sh_ff;
            nxt_on     = on_sh_ff;
            nxt_off    = off_sh_ff;
            nxt_armed  = 1'b1;
            nxt_mcnt   = pstart_ff;
            for (int i = 0; i < 3; i++)
                nxt_pcnt[i] = init_ff;
        end else if (run_ff) begin
            nxt_mcnt = mcnt_ff + 16'h0001;
            for (int i = 0; i < 3; i++)
                nxt_pcnt[i] = pcnt_ff[i] + 16'h0001;
        end
        // Fault holds, clears only at a reload with the fault gone
        if (fault_act)
            nxt_latch = 1'b1;
        else if (master_reload)
            nxt_latch = 1'b0;
        else
            nxt_latch = latch_ff;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pstart_ff <= PSTART_RST;
            pend_ff   <= PEND_RST;
            init_ff   <= INIT_RST;
            mcnt_ff   <= PSTART_RST;
            armed_ff  <= 1'b0;
            latch_ff  <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                on_ff[i]   <= EDGE_ON_RST;
                off_ff[i]  <= EDGE_OFF_RST;
                pcnt_ff[i] <= INIT_RST;
            end
        end else begin
            pstart_ff <= nxt_pstart;
            pend_ff   <= nxt_pend;
            init_ff   <= nxt_init;
            mcnt_ff   <= nxt_mcnt;
            armed_ff  <= nxt_armed;
            latch_ff  <= nxt_latch;
            on_ff     <= nxt_on;
            off_ff    <= nxt_off;
            pcnt_ff   <= nxt_pcnt;
        end
    end

    // Signed window around zero gives center alignment
    always_comb begin
        for (int i = 0; i < 3; i++)
            raw_pwm[i] = ($signed(pcnt_ff[i]) >= $signed(on_ff[i])) &&
                         ($signed(pcnt_ff[i]) < $signed(off_ff[i]));
    end

    // Trigger submodule: half-rate counter reloaded by master
    always_comb begin
        nxt_tick = ~tick_ff;
        nxt_skip = skip_ff;
        nxt_tcnt = tcnt_ff;
        nxt_tarm = tarm_ff;
        nxt_trig = 1'b0;
        if (tick_ff && tarm_ff && tcnt_ff == trig_cmp_ff) begin
            nxt_trig = 1'b1;
            nxt_tarm = 1'b0;
        end
        if (tick_ff && tcnt_ff != 16'hffff)
            nxt_tcnt = tcnt_ff + 16'h0001;
        if (master_reload) begin
            if (skip_ff >= ratio_ff) begin
                nxt_skip = 4'h0;
                nxt_tcnt = 16'h0000;
                nxt_tarm = 1'b1;
            end else begin
                nxt_skip = skip_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tick_ff <= 1'b0;
            skip_ff <= 4'h0;
            tcnt_ff <= 16'h0000;
            tarm_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
            skip_ff <= nxt_skip;
            tcnt_ff <= nxt_tcnt;
            tarm_ff <= nxt_tarm;
            trig_ff <= nxt_trig;
        end
    end

    // Crossbar route to the converter trigger pin
    assign converter_trigger = trig_ff;

    // One dead-time stage per phase leg
    for (genvar g = 0; g < 3; g++) begin : g_leg
        mpw_dead_time u_dt (
            .ref_clk   (ref_clk),
            .resetn    (resetn),
            .raw_pwm   (raw_pwm[g]),
            .out_en    (out_en),
            .dt_first  (dt_first_ff),
            .dt_second (dt_second_ff),
            .pwm_hi    (pwm_hi[g]),
            .pwm_lo    (pwm_lo[g])
        );
    end

    // Cycles since last reload, read only by checks
    logic [15:0] gap_ff;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) gap_ff <= 16'h0000;
        else gap_ff <= master_reload ? 16'h0000 : gap_ff + 16'h0001;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_wrap;
        master_reload |=> mcnt_ff == $past(pstart_ff);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_no_overlap;
        (pwm_hi & pwm_lo) == 3'b000;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("overlap");
    property p_dead_gap;
        $fell(pwm_lo[0]) && dt_first_ff == DTCNT_RST |-> !pwm_hi[0] [*8];
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("short dead");
    property p_period;
        master_reload && armed_ff && $past(run_ff, 2) && pend_ff == PEND_RST
            && pstart_ff == PSTART_RST && gap_ff != 16'h0000
            |-> gap_ff == 16'(PWM_PERIOD_CYC - 1);
    endproperty
    a_period: assert property (p_period) else $error("bad period");
    property p_sync;
        master_reload |=> pcnt_ff[1] == pcnt_ff[0] && pcnt_ff[2] == pcnt_ff[0];
    endproperty
    a_sync: assert property (p_sync) else $error("phase not synced");
    property p_duty_hold;
        !master_reload |=> $stable(on_ff[0]) && $stable(off_ff[0]);
    endproperty
    a_duty_hold: assert property (p_duty_hold) else $error("early load");
    property p_fault_off;
        fault_act |=> pwm_hi == 3'b000 && pwm_lo == 3'b000;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault drive");
    property p_clear_at_reload;
        $fell(latch_ff) |-> $past(master_reload) && !$past(fault_act);
    endproperty
    a_clear_at_reload: assert property (p_clear_at_reload)
        else $error("latch cleared early");
    property p_fault1;
        f1en_ff && !fault1_n |-> fault_act;
    endproperty
    a_fault1: assert property (p_fault1) else $error("fault1 ignored");
    property p_trig_at_cmp;
        $rose(converter_trigger) |-> $past(tcnt_ff) == $past(trig_cmp_ff);
    endproperty
    a_trig_at_cmp: assert property (p_trig_at_cmp) else $error("trig");
    property p_half_rate;
        !tick_ff && !master_reload |=> $stable(tcnt_ff);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("rate");
    property p_skip_bound;
        master_reload |=>
            (skip_ff == 4'h0) == ($past(skip_ff) >= $past(ratio_ff));
    endproperty
    a_skip_bound: assert property (p_skip_bound) else $error("skip");
    property p_unarmed;
        !armed_ff |=> pwm_hi == 3'b000 && pwm_lo == 3'b000;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("early drive");

    c_trigger: cover property ($rose(converter_trigger));
    c_fault_cycle: cover property ($fell(latch_ff));
    c_write: cover property (wr_go);
    c_drive: cover property ($rose(pwm_hi[0]));

endmodule : mpw_motor_pwm_unit

// File: testbench/mpw_power_model.sv
// Power module and dual converter stand-in for the PWM bench
`timescale 1ns/100ps
module mpw_power_model (
    input  wire logic ref_clk,
    input  wire logic fault_req,
    input  wire logic converter_trigger,
    output logic      fault1_n,
    output int        trig_count,
    output int        conv_count,
    output int        chan_sum,
    output int        eos_count
);
    int step_ff;

    // Fault pin idles high, pulled low while the module reports a fault
    assign fault1_n = !fault_req;
    // Each trigger starts one four-slot scan on both converters
    initial begin
        trig_count = 0;
        conv_count = 0;
        chan_sum   = 0;
        eos_count  = 0;
        step_ff    = 0;
    end
    // Converters run in parallel, one slot pair per step
    always @(posedge ref_clk) begin
        if (converter_trigger) begin
            trig_count <= trig_count + 1;
            step_ff    <= 1;
        end else if (step_ff == 1) begin
            // Slots zero and eight: phase currents on input 2
            conv_count <= conv_count + 2;
            chan_sum   <= chan_sum + 2 + 2;
            step_ff    <= 2;
        end else if (step_ff == 2) begin
            // Slots one and nine: bus voltage and temperature, input 1
            conv_count <= conv_count + 2;
            chan_sum   <= chan_sum + 1 + 1;
            eos_count  <= eos_count + 1;
            step_ff    <= 0;
        end
    end
endmodule : mpw_power_model

// File: testbench/mpw_motor_pwm_unit_bench.sv
// Self-checking bench for the motor PWM unit
`timescale 1ns/100ps
module mpw_motor_pwm_unit_bench import mpw_pkg::*;;
    logic        ref_clk, resetn, avs_read, avs_write, fault0, fault_req;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable;
    logic        avs_waitrequest, converter_trigger, fault1_n;
    logic [2:0]  pwm_hi, pwm_lo;
    int          errors, tests_run, cyc, t0, n0, trig_count;
    int          c0, s0, e0, conv_count, chan_sum, eos_count;
    logic [2:0]  hi_seen = 3'h0;

    mpw_motor_pwm_unit DUT (.ref_clk, .resetn, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .fault0, .fault1_n, .pwm_hi, .pwm_lo,
        .converter_trigger);
    mpw_power_model partner (.ref_clk, .fault_req, .converter_trigger,
        .fault1_n, .trig_count, .conv_count, .chan_sum, .eos_count);

    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
        @(posedge ref_clk);
    endtask : bus

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // Reset values, an unmapped place, outputs idle while stopped
    task automatic t_regs;
        logic [7:0]  a [10] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                               8'h2c, 8'h30, 8'h34, 8'h3c};
        logic [31:0] e [10] = '{32'h16, 32'hfe0c, 32'h1f3, 32'hfe0c,
                               32'hff06, 32'hfa, 32'hf, 32'hf, 32'h3, 32'h0};
        bus(1'h1, 8'h3c, 32'h5a5a);
        for (int i = 0; i < 10; i++) begin
            bus(1'h0, a[i], 32'h0);
            check("register", rd, e[i]);
        end
        check("idle outputs", {pwm_hi, pwm_lo}, 6'h00);
        $display("Test regs done");
    endtask : t_regs

    // Period, dead time, and duty loaded only at reload
    task automatic t_run;
        bus(1'h1, 8'h00, 32'h17);
        @(posedge pwm_hi[0]) t0 = cyc;
        @(posedge pwm_hi[0]) check("period", cyc - t0, 1000);
        @(negedge pwm_lo[0]) t0 = cyc;
        @(posedge pwm_hi[0]) check("dead time", cyc - t0, 15);
        t0 = cyc;
        bus(1'h1, 8'h18, 32'h64);
        @(negedge pwm_hi[0]) check("old duty", cyc - t0, 485);
        @(posedge pwm_hi[0]) t0 = cyc;
        @(negedge pwm_hi[0]) check("new duty", cyc - t0, 335);
        $display("Test run done");
    endtask : t_run

    // Sampling ratio one then zero
    task automatic t_trig;
        for (int r = 1; r >= 0; r--) begin
            bus(1'h1, 8'h00, 32'h07 | (r << 4));
            @(posedge converter_trigger) t0 = cyc;
            n0 = trig_count;
            c0 = conv_count;
            s0 = chan_sum;
            e0 = eos_count;
            @(posedge converter_trigger);
            check("trigger gap", cyc - t0, (r + 1) * 1000);
            check("scans", trig_count - n0, 1);
            check("conversions", conv_count - c0, 4);
            check("inputs", chan_sum - s0, 6);
            check("end of scan", eos_count - e0, 1);
        end
        $display("Test trigger done");
    endtask : t_trig

    // Faults blank the outputs until the reload after clearing
    task automatic t_fault;
        fault_req <= 1'h1;
        repeat (3) @(posedge ref_clk);
        check("fault1 blank", {pwm_hi, pwm_lo}, 6'h00);
        fault_req <= 1'h0;
        fault0    <= 1'h1;
        bus(1'h0, 8'h04, 32'h0);
        check("fault status", rd, 32'h7);
        check("fault0 blank", {pwm_hi, pwm_lo}, 6'h00);
        fault0 <= 1'h0;
        t0 = cyc;
        repeat (3) @(posedge ref_clk);
        check("held off", {pwm_hi, pwm_lo}, 6'h00);
        bus(1'h0, 8'h04, 32'h0);
        check("latched status", rd, 32'h5);
        @(posedge pwm_lo[0]) check("restart", pwm_hi[0], 1'h0);
        check("restart at reload", (cyc - t0 > 500) && (cyc - t0 <= 1000),
              1'h1);
        $display("Test fault done");
    endtask : t_fault

    // Clock, cycle count and hang limit
    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = !ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            stop_test();
        end
    end
    // Legs never both on; all phases turn on together, duties may differ
    always @(negedge ref_clk) begin
        check("overlap", pwm_hi & pwm_lo, 3'h0);
        check("sync", pwm_hi & ~hi_seen,
              {3{pwm_hi[0] & ~hi_seen[0]}});
        hi_seen = pwm_hi;
    end

    initial begin
        {avs_read, avs_write, fault0, fault_req} = 4'h0;
        avs_address    = 8'h00;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
        resetn         = 1'h0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'h1;
        @(posedge ref_clk);
        t_regs();
        t_run();
        t_trig();
        t_fault();
        stop_test();
    end
endmodule : mpw_motor_pwm_unit_bench
